// ---- common/irqrp_params.svh ----
// constants of the interrupt readback and poll controller
`ifndef IRQRP_PARAMS_SVH
`define IRQRP_PARAMS_SVH
// ****************************************************************
// register offsets on the software bus
// ****************************************************************
`define IRQRP_OFS_CMD 8'h00
`define IRQRP_OFS_STATUS 8'h04
`define IRQRP_OFS_IRQ_STAT 8'h08
`define IRQRP_OFS_IRQ_MASK 8'h0C
`define IRQRP_OFS_POLL 8'h10
// field positions
`define IRQRP_CMD_OP_LSB 0
`define IRQRP_CMD_BYTE_LSB 8
`define IRQRP_EV_DONE 0
`define IRQRP_EV_ACCEPT 1
`define IRQRP_EV_DEVINT 2
`define IRQRP_MASK_RESET 3'h0
// ****************************************************************
// command operations
// ****************************************************************
`define IRQRP_OP_RD_MASK 3'h0
`define IRQRP_OP_RD_SEL 3'h1
`define IRQRP_OP_SEL_PEND 3'h2
`define IRQRP_OP_SEL_SERV 3'h3
`define IRQRP_OP_POLL 3'h4
`define IRQRP_OP_EOI 3'h5
`define IRQRP_OP_WR_LO 3'h6
`define IRQRP_OP_WR_HI 3'h7
// ****************************************************************
// priority command word layout
// ****************************************************************
`define IRQRP_PCW_BASE 8'h08
`define IRQRP_PCW_POLL 8'h04
`define IRQRP_PCW_RSE 8'h02
`define IRQRP_PCW_SRC 8'h01
`define IRQRP_PCW_EOI 8'h60
`define IRQRP_POLL_FLAG 7
// ****************************************************************
// strobe timing
// ****************************************************************
`define IRQRP_CLK_NS 10
`define IRQRP_T_RD_LOW_NS 160
`define IRQRP_T_WR_LOW_NS 120
`define IRQRP_T_RECOV_NS 120
`define IRQRP_CYC(ns) (((ns) + `IRQRP_CLK_NS - 1) / `IRQRP_CLK_NS)
`define IRQRP_RD_LOW_CYC `IRQRP_CYC(`IRQRP_T_RD_LOW_NS)
`define IRQRP_WR_LOW_CYC `IRQRP_CYC(`IRQRP_T_WR_LOW_NS)
`define IRQRP_RECOV_CYC `IRQRP_CYC(`IRQRP_T_RECOV_NS)
`define IRQRP_RESP_OKAY 2'h0
`define IRQRP_RESP_SLVERR 2'h2
`endif

// ---- common/irqrp_pkg.sv ----
// types of the interrupt readback and poll controller
package irqrp_pkg;
    // pin sequencer states, gray along idle-strobe-hold-recover
    typedef enum logic [1:0] {
        IRQRP_IDLE = 2'h0,
        IRQRP_STROBE = 2'h1,
        IRQRP_HOLD = 2'h3,
        IRQRP_RECOV = 2'h2
    } irqrp_state_t;
    // whole state of the controller
    typedef struct packed {
        irqrp_state_t st;
        logic [7:0] cnt;
        logic [2:0] op;
        logic poll_rd;
        logic busy;
        logic [7:0] rbyte;
        logic [7:0] poll_word;
        logic [2:0] ev;
        logic [2:0] mask;
        logic dint;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic cs;
        logic rd;
        logic wr;
        logic a0;
        logic oe;
        logic [7:0] dout;
    } irqrp_regs_t;
endpackage : irqrp_pkg

// ---- hdl/irqrp_host.sv ----
// host controller driving the interrupt controller's parallel port
`timescale 1ns/1ps
`default_nettype none
`include "irqrp_params.svh"
module irqrp_host #(
    parameter int RD_LOW_CYC = `IRQRP_RD_LOW_CYC,
    parameter int WR_LOW_CYC = `IRQRP_WR_LOW_CYC,
    parameter int RECOV_CYC = `IRQRP_RECOV_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // axi4-lite write address and data
    input wire logic [7:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    // axi4-lite write response
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    // axi4-lite read
    input wire logic [7:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // device parallel port
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic register_select_line_out,
    output logic [7:0] data_out,
    output logic data_oe_out,
    input wire logic [7:0] data_in,
    input wire logic dev_int_in,
    // interrupt to software
    output logic irq_out
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (RD_LOW_CYC < 1 || RD_LOW_CYC > 255 || WR_LOW_CYC < 1 ||
        WR_LOW_CYC > 255 || RECOV_CYC < 1 || RECOV_CYC > 255) begin : g_chk
        $error("strobe counts must lie in 1..255");
    end

    localparam logic [7:0] RD_CYC = 8'(RD_LOW_CYC);
    localparam logic [7:0] WR_CYC = 8'(WR_LOW_CYC);
    localparam logic [7:0] RV_CYC = 8'(RECOV_CYC);

    irqrp_pkg::irqrp_regs_t s_q; // registered state
    irqrp_pkg::irqrp_regs_t s_d; // next state

    // true when an operation reads the device
    function automatic logic op_is_read(input logic [2:0] op,
                                        input logic prd);
        op_is_read = (op == `IRQRP_OP_RD_MASK) ||
                     (op == `IRQRP_OP_RD_SEL) || prd;
    endfunction : op_is_read

    // byte an operation writes to the device
    function automatic logic [7:0] op_byte(input logic [2:0] op,
                                           input logic [7:0] raw,
                                           input logic [2:0] lvl);
        case (op)
            `IRQRP_OP_SEL_PEND: op_byte = `IRQRP_PCW_BASE |
                `IRQRP_PCW_RSE;
            `IRQRP_OP_SEL_SERV: op_byte = `IRQRP_PCW_BASE |
                `IRQRP_PCW_RSE | `IRQRP_PCW_SRC;
            `IRQRP_OP_POLL: op_byte = `IRQRP_PCW_BASE |
                `IRQRP_PCW_POLL;
            `IRQRP_OP_EOI: op_byte = `IRQRP_PCW_EOI |
                {5'h00, lvl};
            default: op_byte = raw;
        endcase
    endfunction : op_byte

    // ****************************************************************
    // handshake outputs
    // ****************************************************************
    assign s_awready_out = !s_q.aw_ok && !s_q.bvalid;
    assign s_wready_out = !s_q.w_ok && !s_q.bvalid;
    assign s_arready_out = !s_q.rvalid;

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    assign s_bvalid_out = s_q.bvalid;
    assign s_bresp_out = s_q.bresp;
    assign s_rvalid_out = s_q.rvalid;
    assign s_rdata_out = s_q.rdata;
    assign s_rresp_out = s_q.rresp;
    assign cs_n_out = !s_q.cs;
    assign rd_n_out = !s_q.rd;
    assign wr_n_out = !s_q.wr;
    assign register_select_line_out = s_q.a0;
    assign data_out = s_q.dout;
    assign data_oe_out = s_q.oe;
    assign irq_out = |(s_q.ev & s_q.mask);

    // next-state logic for bus slave, sequencer and events
    always_comb begin
        logic [2:0] clr;
        logic [2:0] set;
        logic start;
        logic [2:0] nop;
        clr = 3'h0;
        set = 3'h0;
        start = 1'b0;
        nop = s_q.op;
        s_d = s_q;
        // write channel capture, either order
        if (s_awvalid_in && s_awready_out) begin
            s_d.aw_ok = 1'b1;
            s_d.aw_addr = s_awaddr_in;
        end
        if (s_wvalid_in && s_wready_out) begin
            s_d.w_ok = 1'b1;
            s_d.wdata = s_wdata_in;
            s_d.wstrb = s_wstrb_in;
        end
        if (s_q.bvalid && s_bready_in) begin
            s_d.bvalid = 1'b0;
        end
        // perform a write once both halves are held
        if (s_q.aw_ok && s_q.w_ok) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `IRQRP_RESP_OKAY;
            case (s_q.aw_addr)
                `IRQRP_OFS_CMD: begin
                    // commands while busy are dropped
                    if (!s_q.busy && s_q.wstrb[0]) begin
                        start = 1'b1;
                        nop = s_q.wdata[`IRQRP_CMD_OP_LSB +: 3];
                    end
                end
                `IRQRP_OFS_IRQ_STAT: begin
                    if (s_q.wstrb[0]) begin
                        clr = s_q.wdata[2:0];
                    end
                end
                `IRQRP_OFS_IRQ_MASK: begin
                    if (s_q.wstrb[0]) begin
                        s_d.mask = s_q.wdata[2:0];
                    end
                end
                `IRQRP_OFS_STATUS, `IRQRP_OFS_POLL: begin
                    // read-only words ignore writes
                end
                default: begin
                    s_d.bresp = `IRQRP_RESP_SLVERR;
                end
            endcase
        end
        // read channel
        if (s_q.rvalid && s_rready_in) begin
            s_d.rvalid = 1'b0;
        end
        if (s_arvalid_in && s_arready_out) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `IRQRP_RESP_OKAY;
            case (s_araddr_in)
                `IRQRP_OFS_CMD: s_d.rdata = {29'h0, s_q.op};
                `IRQRP_OFS_STATUS: s_d.rdata = {16'h0, s_q.rbyte,
                    6'h0, s_q.poll_rd, s_q.busy};
                `IRQRP_OFS_IRQ_STAT: s_d.rdata = {29'h0, s_q.ev};
                `IRQRP_OFS_IRQ_MASK: s_d.rdata = {29'h0, s_q.mask};
                `IRQRP_OFS_POLL: s_d.rdata = {24'h0, s_q.poll_word};
                default: begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = `IRQRP_RESP_SLVERR;
                end
            endcase
        end
        // pin sequencer
        case (s_q.st)
            irqrp_pkg::IRQRP_IDLE: begin
                if (start) begin
                    s_d.op = nop;
                    s_d.busy = 1'b1;
                    s_d.poll_rd = 1'b0;
                    s_d.st = irqrp_pkg::IRQRP_STROBE;
                    s_d.cs = 1'b1;
                    s_d.a0 = (nop == `IRQRP_OP_RD_MASK) ||
                             (nop == `IRQRP_OP_WR_HI);
                    if (op_is_read(nop, 1'b0)) begin
                        s_d.rd = 1'b1;
                        s_d.cnt = RD_CYC;
                    end else begin
                        s_d.wr = 1'b1;
                        s_d.oe = 1'b1;
                        s_d.cnt = WR_CYC;
                        s_d.dout = op_byte(nop,
                            s_q.wdata[`IRQRP_CMD_BYTE_LSB +: 8],
                            s_q.poll_word[2:0]);
                    end
                end
            end
            irqrp_pkg::IRQRP_STROBE: begin
                s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h01) begin
                    // data settled by the end of the low pulse
                    if (s_q.rd) begin
                        s_d.rbyte = data_in;
                    end
                    s_d.rd = 1'b0;
                    s_d.wr = 1'b0;
                    s_d.st = irqrp_pkg::IRQRP_HOLD;
                end
            end
            irqrp_pkg::IRQRP_HOLD: begin
                // address and data held one cycle past the strobe
                s_d.cs = 1'b0;
                s_d.oe = 1'b0;
                s_d.cnt = RV_CYC;
                s_d.st = irqrp_pkg::IRQRP_RECOV;
            end
            irqrp_pkg::IRQRP_RECOV: begin
                s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h01) begin
                    if (s_q.op == `IRQRP_OP_POLL && !s_q.poll_rd) begin
                        // next read ends the phase, select line low
                        s_d.poll_rd = 1'b1;
                        s_d.cs = 1'b1;
                        s_d.a0 = 1'b0;
                        s_d.rd = 1'b1;
                        s_d.cnt = RD_CYC;
                        s_d.st = irqrp_pkg::IRQRP_STROBE;
                    end else begin
                        if (s_q.poll_rd) begin
                            // accept flag and level kept as read
                            s_d.poll_word = s_q.rbyte;
                            set[`IRQRP_EV_ACCEPT] =
                                s_q.rbyte[`IRQRP_POLL_FLAG];
                        end
                        s_d.busy = 1'b0;
                        set[`IRQRP_EV_DONE] = 1'b1;
                        s_d.st = irqrp_pkg::IRQRP_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = irqrp_pkg::IRQRP_IDLE;
            end
        endcase
        // device interrupt ignored while a poll runs
        s_d.dint = dev_int_in;
        if (dev_int_in && !s_q.dint &&
            !(s_q.busy && s_q.op == `IRQRP_OP_POLL)) begin
            set[`IRQRP_EV_DEVINT] = 1'b1;
        end
        // sticky events, set beats clear
        s_d.ev = (s_q.ev & ~clr) | set;
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s_q <= '{st: irqrp_pkg::IRQRP_IDLE,
                     mask: `IRQRP_MASK_RESET,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end
endmodule : irqrp_host
`default_nettype wire

// ---- verif/irq_status_readback_poll_tb.sv ----
// testbench of the interrupt readback and poll controller
`timescale 1ns/1ps
`default_nettype none
`include "irqrp_params.svh"
module irq_status_readback_poll_tb;
    localparam int CYC = 2; // shortened strobe and recovery counts
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] s_awaddr_in = 8'h00, s_araddr_in = 8'h00, req = 8'h00;
    logic [31:0] s_wdata_in = 32'h0, s_rdata_out;
    logic s_awvalid_in = 1'b0, s_wvalid_in = 1'b0, s_arvalid_in = 1'b0;
    logic s_awready_out, s_wready_out, s_bvalid_out, s_arready_out;
    logic s_rvalid_out, cs_n_out, rd_n_out, wr_n_out, data_oe_out;
    logic register_select_line_out, dev_int, irq_out;
    logic [1:0] s_bresp_out, s_rresp_out;
    logic [7:0] data_out, bus_rd;
    logic [1:0] wr_resp = 2'h0; // response code of the last write
    int error_cnt = 0, check_count = 0;
    always #5 clk_in = ~clk_in;
    irqrp_host #(.RD_LOW_CYC(CYC), .WR_LOW_CYC(CYC), .RECOV_CYC(CYC)) u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .s_awaddr_in(s_awaddr_in),
        .s_awvalid_in(s_awvalid_in), .s_awready_out(s_awready_out),
        .s_wdata_in(s_wdata_in), .s_wstrb_in(4'hF), .s_wvalid_in(s_wvalid_in),
        .s_wready_out(s_wready_out), .s_bresp_out(s_bresp_out),
        .s_bvalid_out(s_bvalid_out), .s_bready_in(1'b1),
        .s_araddr_in(s_araddr_in), .s_arvalid_in(s_arvalid_in),
        .s_arready_out(s_arready_out), .s_rdata_out(s_rdata_out),
        .s_rresp_out(s_rresp_out), .s_rvalid_out(s_rvalid_out),
        .s_rready_in(1'b1), .cs_n_out(cs_n_out), .rd_n_out(rd_n_out),
        .wr_n_out(wr_n_out), .register_select_line_out(register_select_line_out),
        .data_out(data_out), .data_oe_out(data_oe_out), .data_in(bus_rd),
        .dev_int_in(dev_int), .irq_out(irq_out));
    irqrp_dev_model u_dev (.cs_n_in(cs_n_out), .rd_n_in(rd_n_out),
        .wr_n_in(wr_n_out), .register_select_line_in(register_select_line_out),
        .bus_in(data_out), .bus_out(bus_rd), .dev_int_out(dev_int),
        .request_input_in(req));
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // compare one word
    task automatic chk(input string n, input logic [31:0] e, s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // write: offer both halves, drop each once taken, wait for response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ta, tw;
        aw = 1'b1;
        w = 1'b1;
        s_awaddr_in <= a;
        s_wdata_in <= d;
        s_awvalid_in <= 1'b1;
        s_wvalid_in <= 1'b1;
        // local flags track each half; the valids update only after NBA
        while (aw || w) begin
            @(negedge clk_in);
            ta = aw && s_awready_out;
            tw = w && s_wready_out;
            @(posedge clk_in);
            if (ta) s_awvalid_in <= 1'b0;
            if (tw) s_wvalid_in <= 1'b0;
            aw = aw && !ta;
            w = w && !tw;
        end
        do @(negedge clk_in); while (s_bvalid_out !== 1'b1);
        wr_resp = s_bresp_out;
        @(posedge clk_in);
    endtask : axi_wr
    // read: hold the address until taken, then collect data and response
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        s_araddr_in <= a;
        s_arvalid_in <= 1'b1;
        do @(negedge clk_in); while (s_arready_out !== 1'b1);
        @(posedge clk_in);
        s_arvalid_in <= 1'b0;
        do @(negedge clk_in); while (s_rvalid_out !== 1'b1);
        d = s_rdata_out;
        r = s_rresp_out;
        @(posedge clk_in);
    endtask : axi_rd
    task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(n, e, d);
    endtask : chk_reg
    // issue one device operation and wait for busy to drop
    task automatic dev_op(input logic [2:0] op, input logic [7:0] b);
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`IRQRP_OFS_CMD, {16'h0000, b, 5'h00, op});
        do axi_rd(`IRQRP_OFS_STATUS, d, r); while (d[0] !== 1'b0);
    endtask : dev_op
    // device read, then last byte in status
    task automatic op_rd(input logic [2:0] op, input logic [7:0] e);
        dev_op(op, 8'h00);
        chk_reg("status", `IRQRP_OFS_STATUS, {16'h0, e, 8'h00});
    endtask : op_rd
    task automatic chk_irq(input logic e);
        @(negedge clk_in);
        chk("irq", {31'h0, e}, {31'h0, irq_out});
        // next request starts just after a rising edge
        @(posedge clk_in);
    endtask : chk_irq
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        chk_reg("status", `IRQRP_OFS_STATUS, 32'h0);
        chk_irq(1'b0);
        axi_wr(`IRQRP_OFS_IRQ_MASK, 32'h7);
        chk("wresp", {30'h0, `IRQRP_RESP_OKAY}, {30'h0, wr_resp});
        req <= 8'h5A;
        dev_op(`IRQRP_OP_WR_HI, 8'h0F);
        op_rd(`IRQRP_OP_RD_MASK, 8'h0F);
        dev_op(`IRQRP_OP_SEL_PEND, 8'h00);
        op_rd(`IRQRP_OP_RD_SEL, 8'h5A);
        op_rd(`IRQRP_OP_RD_SEL, 8'h5A);
        dev_op(`IRQRP_OP_SEL_SERV, 8'h00);
        op_rd(`IRQRP_OP_RD_SEL, 8'h00);
        dev_op(`IRQRP_OP_WR_HI, 8'h00);
        dev_op(`IRQRP_OP_POLL, 8'h00);
        chk_reg("poll", `IRQRP_OFS_POLL, 32'h81);
        op_rd(`IRQRP_OP_RD_SEL, 8'h02);
        dev_op(`IRQRP_OP_EOI, 8'h00);
        op_rd(`IRQRP_OP_RD_SEL, 8'h00);
        req <= 8'h00;
        dev_op(`IRQRP_OP_POLL, 8'h00);
        chk_reg("poll", `IRQRP_OFS_POLL, 32'h00);
        req <= 8'h10;
        dev_op(`IRQRP_OP_WR_LO, 8'h0C);
        op_rd(`IRQRP_OP_RD_MASK, 8'h00);
        op_rd(`IRQRP_OP_RD_SEL, 8'h10);
        chk_reg("istat", `IRQRP_OFS_IRQ_STAT, 32'h7);
        chk_irq(1'b1);
        axi_wr(`IRQRP_OFS_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        axi_wr(`IRQRP_OFS_IRQ_MASK, 32'h7);
        axi_wr(`IRQRP_OFS_IRQ_STAT, 32'h7);
        chk_reg("istat", `IRQRP_OFS_IRQ_STAT, 32'h0);
        chk_irq(1'b0);
        axi_rd(8'h20, d, r);
        chk("unmapped", 32'h0, d);
        chk("resp", {30'h0, `IRQRP_RESP_SLVERR}, {30'h0, r});
        axi_wr(8'h20, 32'h0);
        chk("wresp", {30'h0, `IRQRP_RESP_SLVERR}, {30'h0, wr_resp});
        end_sim;
    end
    // the sequence needs a few hundred cycles; this allows 30000 cycles
    initial begin
        #300000;
        error_cnt++;
        end_sim;
    end
endmodule : irq_status_readback_poll_tb
bind irqrp_host irqrp_host_assertions #(.RD_LOW_CYC(RD_LOW_CYC),
    .WR_LOW_CYC(WR_LOW_CYC), .RECOV_CYC(RECOV_CYC)) u_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .s_awvalid_in(s_awvalid_in),
    .s_awready_out(s_awready_out), .s_wvalid_in(s_wvalid_in),
    .s_wready_out(s_wready_out), .s_bvalid_out(s_bvalid_out),
    .s_arready_out(s_arready_out), .s_rvalid_out(s_rvalid_out),
    .s_rready_in(s_rready_in), .cs_n_out(cs_n_out), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .register_select_line_out(register_select_line_out),
    .data_out(data_out), .data_oe_out(data_oe_out));
`default_nettype wire

// ---- verif/irqrp_dev_model.sv ----
// behavioural model of the interrupt controller's host port
`timescale 1ns/1ps
`default_nettype none
module irqrp_dev_model (
    // host port
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic register_select_line_in,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic dev_int_out,
    // request lines from the bench
    input wire logic [7:0] request_input_in
);
    logic [7:0] mask_q = 8'h00; // interrupt_mask_reg
    logic [7:0] isr_q = 8'h00; // in_service_reg
    logic src_q = 1'b0; // read source, kept across reads
    logic poll_q = 1'b0; // polling phase
    logic [7:0] rd_q = 8'h00; // byte latched at read strobe fall
    logic [2:0] lvl; // highest-priority unmasked request
    assign dev_int_out = |(request_input_in & ~mask_q);
    // released bus shows the inverse of the last byte, never a held value
    assign bus_out = (!cs_n_in && !rd_n_in) ? rd_q : ~rd_q;
    // level 0 wins
    always_comb begin
        lvl = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (request_input_in[i] && !mask_q[i]) lvl = 3'(i);
        end
    end
    // commands land at the strobe's rising edge
    always @(posedge wr_n_in) begin
        if (!cs_n_in && register_select_line_in) begin
            mask_q <= bus_in;
        end else if (!cs_n_in && bus_in[7:3] == 5'h0C) begin
            isr_q[bus_in[2:0]] <= 1'b0;
        end else if (!cs_n_in && bus_in[7:3] == 5'h01) begin
            poll_q <= bus_in[2];
            if (bus_in[1]) src_q <= bus_in[0];
        end
    end
    // reads: mask at select high, else poll word while polling or chosen raw register
    // select and chip-select change in the same step as the strobe
    always @(negedge rd_n_in) begin
        #1;
        if (!cs_n_in && poll_q) begin
            poll_q <= 1'b0;
            if (dev_int_out) isr_q[lvl] <= 1'b1;
            rd_q <= register_select_line_in ? mask_q :
                {dev_int_out, 4'h0, lvl};
        end else if (!cs_n_in) begin
            rd_q <= register_select_line_in ? mask_q :
                (src_q ? isr_q : request_input_in);
        end
    end
endmodule : irqrp_dev_model
`default_nettype wire

// ---- verif/irqrp_host_assertions.sv ----
// checker of the host controller's bus and device-port timing
`timescale 1ns/1ps
`default_nettype none
module irqrp_host_assertions #(
    parameter int RD_LOW_CYC = 16,
    parameter int WR_LOW_CYC = 12,
    parameter int RECOV_CYC = 12
) (
    // clock, reset and software bus
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic s_awvalid_in,
    input wire logic s_awready_out,
    input wire logic s_wvalid_in,
    input wire logic s_wready_out,
    input wire logic s_bvalid_out,
    input wire logic s_arready_out,
    input wire logic s_rvalid_out,
    input wire logic s_rready_in,
    // device port
    input wire logic cs_n_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic register_select_line_out,
    input wire logic [7:0] data_out,
    input wire logic data_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] rd_lo_q, wr_lo_q, cs_hi_q; // strobe-low and idle counts
    // count strobe widths; idle count saturates so reset looks long idle
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rd_lo_q <= 8'h00;
            wr_lo_q <= 8'h00;
            cs_hi_q <= 8'hFF;
        end else begin
            rd_lo_q <= rd_n_out ? 8'h00 : rd_lo_q + 8'h01;
            wr_lo_q <= wr_n_out ? 8'h00 : wr_lo_q + 8'h01;
            cs_hi_q <= (!cs_n_out) ? 8'h00 : cs_hi_q + {7'h00, ~&cs_hi_q};
        end
    end
    AST_STROBE_CS:
    assert property ((!rd_n_out || !wr_n_out) |-> !cs_n_out &&
        (rd_n_out || wr_n_out)) else $error("strobe without select");
    AST_RD_WIDTH:
    assert property ($rose(rd_n_out) |-> rd_lo_q == 8'(RD_LOW_CYC))
        else $error("read strobe width wrong");
    AST_WR_WIDTH:
    assert property ($rose(wr_n_out) |-> wr_lo_q == 8'(WR_LOW_CYC))
        else $error("write strobe width wrong");
    AST_HOLD:
    assert property (($rose(rd_n_out) || $rose(wr_n_out)) |-> !cs_n_out &&
        $stable(register_select_line_out) ##1 cs_n_out)
        else $error("hold cycle wrong");
    AST_RECOVERY:
    assert property ($fell(cs_n_out) |-> cs_hi_q >= 8'(RECOV_CYC))
        else $error("recovery too short");
    AST_WR_DATA:
    assert property (!wr_n_out && !$past(wr_n_out) |-> data_oe_out &&
        $stable(data_out) && $stable(register_select_line_out))
        else $error("write byte moved");
    AST_RD_FLOAT:
    assert property (!rd_n_out |-> !data_oe_out && (!$past(rd_n_out) ->
        $stable(register_select_line_out))) else $error("read contention");
    AST_B_AFTER:
    assert property (s_awvalid_in && s_awready_out && s_wvalid_in &&
        s_wready_out |=> !s_awready_out ##1 s_bvalid_out && !s_awready_out)
        else $error("write response late");
    AST_R_DROP:
    assert property (s_rvalid_out && s_rready_in |=> !s_rvalid_out &&
        s_arready_out) else $error("read valid stuck");
    AST_AR_READY:
    assert property (s_arready_out == !s_rvalid_out)
        else $error("arready wrong");
endmodule : irqrp_host_assertions
`default_nettype wire
